// [include/clock_gen_pkg.sv]
// Constants and types shared by the clock reference, prescaler and divider block
package clock_gen_pkg;
	localparam int CFG_W = 9;
	// Mode word field positions
	localparam int REF_SEL_POS = 0;
	localparam int DIV_BYPASS_POS = 1;
	localparam int PRE_BYPASS_POS = 2;
	localparam int PRE_RATIO_POS = 3;
	localparam int PIN_FUNC_POS = 4;
	localparam int REF_DIS_POS = 5;
	localparam int MODE_ZERO_LSB = 6;
	// Reset values of the active configuration
	localparam logic [8:0] MODE_RESET = 9'h000;
	localparam logic [8:0] DIVIDER_RESET = 9'h000;
	// Divisor is the programmed field plus this offset
	localparam logic [9:0] DIVISOR_OFFSET = 10'h002;
	// Power and output sequencing states
	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_DRAIN = 3'b010,
		ST_OFF = 3'b100
	} power_state_e;
endpackage : clock_gen_pkg

// [design/clock_ref_select_divider_gate.sv]
// Reference select, prescaler, N divider and synchronous output gating
`timescale 1ns/1ns
module clock_ref_select_divider_gate
	import clock_gen_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [8:0] modeConfigWord,
	input wire logic [8:0] dividerConfigWord,
	input wire logic internalOscillator,
	input wire logic externalRefClock,
	input wire logic powerdownOrRefselPin,
	input wire logic outputEnable,
	output logic mainClkOut,
	output logic mainClkOe,
	output logic referenceClockOutput,
	output logic referenceClockOe,
	output logic poweredDown
);
	typedef struct packed {
		power_state_e st;
		logic [5:0] mode;
		logic [8:0] nField;
		logic oscPrev;
		logic [1:0] pre;
		logic masterPrev;
		logic oeSync;
		logic enSample;
		logic running;
		logic [9:0] cnt;
		logic mainOut;
		logic gateOne;
		logic refOut;
	} state_s;

	state_s cur_q, nxt_d;

	logic pinFunctionBit, refSelBit, dividerBypassBit, prescalerBypassBit;
	logic prescalerRatioBit, refOutputDisableBit, externalSel;
	logic masterClk, masterRise, masterFall, oscRise;
	logic [9:0] divisor, hiLen;
	logic [9:0] cntNext;
	logic stopReq, powerdownReq;

	assign pinFunctionBit = cur_q.mode[PIN_FUNC_POS];
	assign refSelBit = cur_q.mode[REF_SEL_POS];
	assign dividerBypassBit = cur_q.mode[DIV_BYPASS_POS];
	assign prescalerBypassBit = cur_q.mode[PRE_BYPASS_POS];
	assign prescalerRatioBit = cur_q.mode[PRE_RATIO_POS];
	assign refOutputDisableBit = cur_q.mode[REF_DIS_POS];

	// Reference choice is live from the pin when it acts as a select
	assign externalSel = pinFunctionBit ? refSelBit : ~powerdownOrRefselPin;
	assign powerdownReq = pinFunctionBit & ~powerdownOrRefselPin;

	assign oscRise = internalOscillator & ~cur_q.oscPrev;

	always_comb begin
		if (externalSel) begin
			masterClk = externalRefClock;
		end else if (prescalerBypassBit) begin
			masterClk = internalOscillator;
		end else begin
			masterClk = prescalerRatioBit ? cur_q.pre[0] : cur_q.pre[1];
		end
	end

	assign masterRise = masterClk & ~cur_q.masterPrev;
	assign masterFall = ~masterClk & cur_q.masterPrev;
	assign divisor = {1'b0, cur_q.nField} + DIVISOR_OFFSET;
	assign hiLen = (divisor + 10'h001) >> 1;
	assign cntNext = (cur_q.cnt == divisor - 10'h001) ? 10'h000 : cur_q.cnt + 10'h001;
	assign stopReq = ~cur_q.enSample | ~cur_q.st[0];

	always_comb begin
		nxt_d = cur_q;
		nxt_d.oscPrev = internalOscillator;
		nxt_d.masterPrev = masterClk;
		nxt_d.oeSync = outputEnable;
		if (oscRise) begin
			nxt_d.pre = cur_q.pre + 2'h1;
		end
		// Enable captured only at master rising edges; a change in the
		// cycle of the edge is seen one master period later
		if (masterRise) begin
			nxt_d.enSample = cur_q.oeSync;
		end
		if (dividerBypassBit) begin
			// Gate moves only while the master clock is low
			if (masterFall) begin
				nxt_d.gateOne = cur_q.enSample & cur_q.st[0];
			end
			nxt_d.mainOut = masterClk & cur_q.gateOne;
			nxt_d.running = 1'b0;
			nxt_d.cnt = 10'h000;
		end else begin
			nxt_d.gateOne = 1'b0;
			if (masterRise) begin
				if (cur_q.running) begin
					if (stopReq && !cur_q.mainOut) begin
						nxt_d.running = 1'b0;
						nxt_d.cnt = 10'h000;
					end else if (stopReq && cntNext >= hiLen) begin
						nxt_d.running = 1'b0;
						nxt_d.cnt = 10'h000;
						nxt_d.mainOut = 1'b0;
					end else begin
						nxt_d.cnt = cntNext;
						nxt_d.mainOut = cntNext < hiLen;
					end
				end else if (!stopReq) begin
					nxt_d.running = 1'b1;
					nxt_d.cnt = 10'h000;
					nxt_d.mainOut = 1'b1;
				end else begin
					nxt_d.cnt = 10'h000;
					nxt_d.mainOut = 1'b0;
				end
			end
		end
		// Reference output follows the master clock regardless of enable
		nxt_d.refOut = masterClk & ~refOutputDisableBit & ~cur_q.st[2];
		case (cur_q.st)
			ST_RUN: begin
				if (powerdownReq) begin
					nxt_d.st = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				if (!cur_q.mainOut && !cur_q.running && !masterClk && !cur_q.gateOne) begin
					nxt_d.st = ST_OFF;
					nxt_d.refOut = 1'b0;
				end
			end
			ST_OFF: begin
				nxt_d.mainOut = 1'b0;
				nxt_d.gateOne = 1'b0;
				nxt_d.enSample = 1'b0;
				nxt_d.refOut = 1'b0;
				if (!powerdownReq) begin
					// New configuration is taken only on power-up
					nxt_d.mode = modeConfigWord[MODE_ZERO_LSB-1:0];
					nxt_d.nField = dividerConfigWord;
					nxt_d.st = ST_RUN;
				end
			end
			default: begin
				nxt_d.st = ST_OFF;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cur_q.st <= ST_OFF;
			cur_q.mode <= MODE_RESET[MODE_ZERO_LSB-1:0];
			cur_q.nField <= DIVIDER_RESET;
			cur_q.oscPrev <= 1'b0;
			cur_q.pre <= 2'h0;
			cur_q.masterPrev <= 1'b0;
			cur_q.oeSync <= 1'b0;
			cur_q.enSample <= 1'b0;
			cur_q.running <= 1'b0;
			cur_q.cnt <= 10'h000;
			cur_q.mainOut <= 1'b0;
			cur_q.gateOne <= 1'b0;
			cur_q.refOut <= 1'b0;
		end else begin
			cur_q <= nxt_d;
		end
	end

	assign mainClkOut = cur_q.mainOut;
	assign mainClkOe = ~cur_q.st[2];
	assign referenceClockOutput = cur_q.refOut;
	assign referenceClockOe = ~refOutputDisableBit & ~cur_q.st[2];
	assign poweredDown = cur_q.st[2];

	// Helper: master rises seen while the main output stays high
	logic [9:0] hiRises_q;
	always_ff @(posedge clk_sys) begin
		if (rst || !cur_q.mainOut) begin
			hiRises_q <= 10'h000;
		end else if (masterRise) begin
			hiRises_q <= hiRises_q + 10'h001;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence sStartEdge;
		masterRise && !cur_q.running && !stopReq && !dividerBypassBit;
	endsequence

	sequence sIdleEdge;
		masterRise && !cur_q.running && stopReq && !dividerBypassBit;
	endsequence

	sequence sStopLowEdge;
		masterRise && cur_q.running && stopReq && !cur_q.mainOut && !dividerBypassBit;
	endsequence

	a_ref_disable_float: assert property (
		refOutputDisableBit |-> !referenceClockOe && !referenceClockOutput)
		else $error("reference output not floated while disabled");

	a_powerdown_hiz: assert property (
		cur_q.st == ST_OFF |-> !mainClkOe && !referenceClockOe && !mainClkOut)
		else $error("outputs driven in power-down");

	a_powerdown_enter: assert property (
		cur_q.st == ST_RUN && powerdownReq |=> cur_q.st == ST_DRAIN)
		else $error("power-down request not taken");

	a_enable_first_edge: assert property (
		sStartEdge |=> mainClkOut && cur_q.cnt == 10'h000)
		else $error("output did not start on sampled enable");

	a_idle_held_low: assert property (
		sIdleEdge |=> !mainClkOut && cur_q.cnt == 10'h000)
		else $error("disabled output not held low");

	a_pulse_whole: assert property (
		$fell(mainClkOut) && !dividerBypassBit && $past(!dividerBypassBit)
			|-> hiRises_q == hiLen)
		else $error("output pulse truncated");

	a_external_direct: assert property (
		externalSel && cur_q.st == ST_RUN && !refOutputDisableBit
			|=> referenceClockOutput == $past(externalRefClock))
		else $error("external reference not passed unscaled");

	a_bypass_follow: assert property (
		dividerBypassBit && cur_q.gateOne && $stable(cur_q.mode)
			|=> mainClkOut == $past(masterClk))
		else $error("bypass output does not follow master clock");

	a_oe_ignores_ref: assert property (
		!cur_q.oeSync && cur_q.st == ST_RUN && !refOutputDisableBit
			|=> referenceClockOe && referenceClockOutput == $past(masterClk))
		else $error("enable affected reference output");

	a_divider_wrap: assert property (
		cur_q.running && masterRise && !stopReq && cur_q.cnt == divisor - 10'h001
			|=> cur_q.cnt == 10'h000 && mainClkOut)
		else $error("divider did not wrap at field plus two");

	a_enable_capture: assert property (
		masterRise && cur_q.st != ST_OFF |=> cur_q.enSample == $past(cur_q.oeSync))
		else $error("enable not captured at master rise");

	a_enable_hold: assert property (
		!masterRise && cur_q.st != ST_OFF |=> $stable(cur_q.enSample))
		else $error("enable sample moved between master rises");

	a_late_fall_stop: assert property (
		sStopLowEdge |=> !cur_q.running && !mainClkOut)
		else $error("divider not stopped on low output");

	a_gate_close: assert property (
		dividerBypassBit && masterFall && !(cur_q.enSample && cur_q.st == ST_RUN)
			|=> !cur_q.gateOne)
		else $error("bypass gate not closed on master fall");

	a_gate_open: assert property (
		dividerBypassBit && masterFall && cur_q.enSample && cur_q.st == ST_RUN
			|=> cur_q.gateOne)
		else $error("bypass gate not opened on master fall");

	a_idle_count_zero: assert property (
		!cur_q.running |-> cur_q.cnt == 10'h000)
		else $error("divider counter not held at zero while idle");

	a_config_frozen: assert property (
		cur_q.st != ST_OFF |=> $stable(cur_q.mode) && $stable(cur_q.nField))
		else $error("configuration changed while running");

	a_pin_select_ext: assert property (
		!pinFunctionBit && !powerdownOrRefselPin && cur_q.st == ST_RUN && !refOutputDisableBit
			|=> referenceClockOutput == $past(externalRefClock))
		else $error("select pin low did not pick external reference");

	a_powerdown_no_trunc: assert property (
		$rose(poweredDown) |-> !$past(mainClkOut) && !mainClkOut)
		else $error("main output cut short by power-down");
endmodule : clock_ref_select_divider_gate

// [bench/clock_sink.sv]
// Downstream board logic measuring the generated clocks
`timescale 1ns/1ns
module clock_sink (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic mainClkOut,
	input wire logic mainClkOe,
	input wire logic referenceClockOutput,
	input wire logic referenceClockOe,
	output logic [15:0] mainPeriod,
	output logic [15:0] mainHigh,
	output logic [15:0] mainRises,
	output logic [15:0] refRises
);
	logic [15:0] age;
	logic mainQ;
	logic refQ;
	// A floating pin reads as low here
	wire mainNow = mainClkOe & mainClkOut;
	wire refNow = referenceClockOe & referenceClockOutput;
	always_ff @(posedge clk_sys) begin
		mainQ <= mainNow;
		refQ <= refNow;
		age <= age + 16'h0001;
		if (rst) begin
			mainRises <= 16'h0000;
			refRises <= 16'h0000;
		end else begin
			if (mainNow && !mainQ) begin
				mainPeriod <= age;
				age <= 16'h0001;
				mainRises <= mainRises + 16'h0001;
			end
			if (mainQ && !mainNow)
				mainHigh <= age;
			if (refNow && !refQ)
				refRises <= refRises + 16'h0001;
		end
	end
endmodule : clock_sink

// [bench/tb.sv]
// Self-checking bench for the clock select, prescaler and divider block
`timescale 1ns/1ns
module tb;
	import clock_gen_pkg::*;
	typedef struct {
		logic [8:0] m;
		logic [8:0] d;
		logic p;
		logic [15:0] per;
		logic [15:0] hi;
		logic ro;
	} row_s;
	// Settings keep the output rate well above the minimum
	row_s rows [9] = '{
		'{9'h014, 9'h000, 1'b1, 16'h0008, 16'h0004, 1'b1},
		'{9'h011, 9'h001, 1'b1, 16'h0012, 16'h000c, 1'b1},
		'{9'h010, 9'h000, 1'b1, 16'h0020, 16'h0010, 1'b1},
		'{9'h018, 9'h000, 1'b1, 16'h0010, 16'h0008, 1'b1},
		'{9'h016, 9'h1ff, 1'b1, 16'h0004, 16'h0002, 1'b1},
		'{9'h000, 9'h000, 1'b0, 16'h000c, 16'h0006, 1'b1},
		'{9'h000, 9'h000, 1'b1, 16'h0020, 16'h0010, 1'b1},
		'{9'h031, 9'h000, 1'b1, 16'h000c, 16'h0006, 1'b0},
		'{9'h014, 9'h1ff, 1'b1, 16'h0804, 16'h0404, 1'b1}
	};
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [8:0] modeW = 9'h014;
	logic [8:0] divW = 9'h000;
	logic internal_oscillator = 1'b0;
	logic extOsc = 1'b0;
	logic pin = 1'b1;
	logic oe = 1'b1;
	logic mainOut, mainOe, refOut, refOe, down;
	logic [15:0] per, hi, rises, refRises, sv, svRef;
	int failures = 0;
	int check_count = 0;
	int n;
	clock_ref_select_divider_gate u_dut (.clk_sys(clk_sys), .rst(rst),
		.modeConfigWord(modeW), .dividerConfigWord(divW), .internalOscillator(internal_oscillator),
		.externalRefClock(extOsc), .powerdownOrRefselPin(pin), .outputEnable(oe),
		.mainClkOut(mainOut), .mainClkOe(mainOe), .referenceClockOutput(refOut),
		.referenceClockOe(refOe), .poweredDown(down));
	clock_sink u_sink (.clk_sys(clk_sys), .rst(rst), .mainClkOut(mainOut),
		.mainClkOe(mainOe), .referenceClockOutput(refOut), .referenceClockOe(refOe),
		.mainPeriod(per), .mainHigh(hi), .mainRises(rises), .refRises(refRises));
	initial forever #10 clk_sys = ~clk_sys;
	initial begin
		#11;
		forever #40 internal_oscillator = ~internal_oscillator;
	end
	initial begin
		#11;
		forever #60 extOsc = ~extOsc;
	end
	task automatic print_verdict();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick();
		@(posedge clk_sys);
		#1;
		n++;
		if (n > 9000) begin
			failures++;
			print_verdict();
		end
	endtask : tick
	task automatic waitRises(input logic [15:0] k);
		sv = rises;
		n = 0;
		while (rises - sv < k)
			tick();
	endtask : waitRises
	task automatic doReset();
		rst = 1'b1;
		repeat (3) tick();
		rst = 1'b0;
	endtask : doReset
	initial begin
		foreach (rows[i]) begin
			modeW = rows[i].m;
			divW = rows[i].d;
			pin = rows[i].p;
			doReset();
			waitRises(16'h0003);
			check(per, rows[i].per);
			check(hi, rows[i].hi);
			check({15'h0000, refOe}, {15'h0000, rows[i].ro});
			$display("row %0d done", i);
		end
		modeW = 9'h014;
		divW = 9'h000;
		doReset();
		waitRises(16'h0002);
		divW = 9'h001;
		waitRises(16'h0003);
		check(per, 16'h0008);
		pin = 1'b0;
		n = 0;
		while (down !== 1'b1)
			tick();
		check({14'h0000, mainOe, refOe}, 16'h0000);
		pin = 1'b1;
		waitRises(16'h0003);
		check(per, 16'h000c);
		check({15'h0000, down}, 16'h0000);
		$display("power cycle done");
		oe = 1'b0;
		repeat (40) tick();
		sv = rises;
		svRef = refRises;
		repeat (40) tick();
		check(rises, sv);
		check({15'h0000, mainOut}, 16'h0000);
		check({15'h0000, refRises != svRef}, 16'h0001);
		oe = 1'b1;
		n = 0;
		while (rises == sv)
			tick();
		check({15'h0000, n >= 5 && n <= 12}, 16'h0001);
		oe = 1'b0;
		repeat (40) tick();
		check(hi, 16'h0008);
		$display("enable gating done");
		modeW = 9'h016;
		oe = 1'b1;
		doReset();
		waitRises(16'h0003);
		sv = rises;
		oe = 1'b0;
		repeat (40) tick();
		check({15'h0000, rises - sv == 16'h0001 || rises - sv == 16'h0002}, 16'h0001);
		check({15'h0000, mainOut}, 16'h0000);
		$display("bypass disable done");
		print_verdict();
	end
endmodule : tb
